// ==== hw/jxle_top.sv ====
// Extra serial lane enable registers and lane control for links A and B
`timescale 1ns/1ps
`default_nettype none
module jxle_top (
  input  wire  logic                       aclk,
  input  wire  logic                       aresetn,
  input  wire  logic [11:0]                s_axi_awaddr,
  input  wire  logic [2:0]                 s_axi_awprot,
  input  wire  logic                       s_axi_awvalid,
  output var   logic                       s_axi_awready,
  input  wire  logic [31:0]                s_axi_wdata,
  input  wire  logic [3:0]                 s_axi_wstrb,
  input  wire  logic                       s_axi_wvalid,
  output var   logic                       s_axi_wready,
  output var   logic [1:0]                 s_axi_bresp,
  output var   logic                       s_axi_bvalid,
  input  wire  logic                       s_axi_bready,
  input  wire  logic [11:0]                s_axi_araddr,
  input  wire  logic [2:0]                 s_axi_arprot,
  input  wire  logic                       s_axi_arvalid,
  output var   logic                       s_axi_arready,
  output var   logic [31:0]                s_axi_rdata,
  output var   logic [1:0]                 s_axi_rresp,
  output var   logic                       s_axi_rvalid,
  input  wire  logic                       s_axi_rready,
  input  wire  logic [7:0]                 format_lanes_a,
  input  wire  logic [7:0]                 format_lanes_b,
  output var   jxle_pkg::jxle_lanes_t      lanes_a,
  output var   jxle_pkg::jxle_lanes_t      lanes_b,
  output var   logic                       serial_subsystem_on
);

  // Per-link lane enables, serializer gating and pattern choice
  function automatic jxle_pkg::jxle_lanes_t link_lanes(
    input jxle_pkg::jxle_extra_t x,
    input logic [7:0]            fmt,
    input logic                  on,
    input logic [3:0]            tsel
  );
    jxle_pkg::jxle_lanes_t r;
    logic [7:0]            extra;
    logic [7:0]            want;
    logic                  chain;
    logic                  ser_want;
    r     = '0;
    extra = {x.lanes, 1'b0};
    want  = fmt | extra;
    chain = 1'b1;
    for (int n = 0; n < jxle_pkg::LANES; n++) begin
      r.clk_en[n] = on & want[n];
      ser_want    = on & (fmt[n] | (extra[n] & x.ser_on));
      r.ser_en[n] = ser_want & chain;
      chain       = chain & want[n];
      if (extra[n] && !fmt[n] &&
          (tsel == jxle_pkg::TEST_NONE || tsel == jxle_pkg::TEST_ALT)) begin
        r.pattern[n] = jxle_pkg::TEST_RAMP;
      end else begin
        r.pattern[n] = tsel;
      end
    end
    return r;
  endfunction

  // One-hot register select shared by the write and read paths
  function automatic logic [3:0] addr_hit(
    input logic [11:0] addr
  );
    logic [3:0] hit;
    hit[0] = addr == jxle_pkg::ADDR_LINK_A;
    hit[1] = addr == jxle_pkg::ADDR_LINK_B;
    hit[2] = addr == jxle_pkg::ADDR_CTRL;
    hit[3] = addr == jxle_pkg::ADDR_STAT;
    return hit;
  endfunction

  // Software visible registers
  logic [7:0]                 extra_a;
  logic [7:0]                 extra_b;
  logic [7:0]                 ctrl;
  // Copies in use by the lanes
  jxle_pkg::jxle_extra_t      live_a;
  jxle_pkg::jxle_extra_t      live_b;
  logic                       link_en_q;

  // Write channel state
  jxle_pkg::jxle_wr_state_t   wr_state;
  logic                       aw_have;
  logic                       w_have;
  logic [11:0]                wr_addr;
  logic [31:0]                wr_data;
  logic [3:0]                 wr_strb;
  // Read channel state
  jxle_pkg::jxle_rd_state_t   rd_state;

  // Control decode
  wire logic                  link_en;
  wire logic                  pd_a;
  wire logic                  pd_b;
  wire logic [3:0]            test_sel;
  wire logic                  link_rise;
  wire logic                  link_run;
  wire logic                  sub_on;
  wire logic                  link_a_on;
  wire logic                  link_b_on;

  assign link_en   = ctrl[jxle_pkg::LINK_EN_BIT];
  assign pd_a      = ctrl[jxle_pkg::PD_A_BIT];
  assign pd_b      = ctrl[jxle_pkg::PD_B_BIT];
  assign test_sel  = ctrl[jxle_pkg::TEST_MSB:jxle_pkg::TEST_LSB];
  assign link_rise = link_en & ~link_en_q;
  // Lanes wait one cycle after enable, else stale settings flash for a cycle
  assign link_run  = link_en & link_en_q;
  assign sub_on    = ~(pd_a & pd_b);
  assign link_a_on = link_run & sub_on & ~pd_a;
  assign link_b_on = link_run & sub_on & ~pd_b;

  // Lane outputs
  wire jxle_pkg::jxle_lanes_t next_lanes_a;
  wire jxle_pkg::jxle_lanes_t next_lanes_b;

  assign next_lanes_a = link_lanes(live_a, format_lanes_a, link_a_on, test_sel);
  assign next_lanes_b = link_lanes(live_b, format_lanes_b, link_b_on, test_sel);

  // Write decode
  wire logic                  aw_fire;
  wire logic                  w_fire;
  wire logic                  wr_commit;
  wire logic                  wr_lane0;
  wire logic                  wr_hit_a;
  wire logic                  wr_hit_b;
  wire logic                  wr_hit_ctrl;
  wire logic [3:0]            wr_sel;
  wire logic                  wr_ok;
  wire logic [11:0]           next_wr_addr;
  wire logic [31:0]           next_wr_data;
  wire logic [3:0]            next_wr_strb;

  assign aw_fire      = s_axi_awvalid & s_axi_awready;
  assign w_fire       = s_axi_wvalid & s_axi_wready;
  assign next_wr_addr = aw_fire ? s_axi_awaddr : wr_addr;
  assign next_wr_data = w_fire ? s_axi_wdata : wr_data;
  assign next_wr_strb = w_fire ? s_axi_wstrb : wr_strb;
  // Address and data may arrive in either order, or together
  assign wr_commit    = (wr_state == jxle_pkg::JXLE_WR_ACCEPT) &&
                        (aw_have | aw_fire) && (w_have | w_fire);
  assign wr_lane0     = next_wr_strb[0];
  assign wr_sel       = addr_hit(next_wr_addr);
  assign wr_hit_a     = wr_sel[0];
  assign wr_hit_b     = wr_sel[1];
  assign wr_hit_ctrl  = wr_sel[2];
  assign wr_ok        = wr_hit_a | wr_hit_b | wr_hit_ctrl;

  // Read decode
  wire logic                  ar_fire;
  wire logic                  rd_hit;
  wire logic [3:0]            rd_sel;
  wire logic [31:0]           rd_word;
  wire logic [31:0]           stat_word;

  assign ar_fire   = s_axi_arvalid & s_axi_arready;
  assign stat_word = {lanes_b.ser_en, lanes_b.clk_en, lanes_a.ser_en, lanes_a.clk_en};
  assign rd_sel    = addr_hit(s_axi_araddr);
  assign rd_hit    = |rd_sel;
  assign rd_word   = rd_sel[0] ? {24'h000000, extra_a} :
                     rd_sel[1] ? {24'h000000, extra_b} :
                     rd_sel[2] ? {24'h000000, ctrl} :
                     rd_sel[3] ? stat_word : 32'h00000000;

  // Register file; link register writes while the link runs are stored but not applied
  // Only byte lane 0 holds bits; a write without it is answered and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      extra_a <= jxle_pkg::EXTRA_RST;
      extra_b <= jxle_pkg::EXTRA_RST;
      ctrl    <= jxle_pkg::CTRL_RST;
    end else if (wr_commit && wr_lane0) begin
      if (wr_hit_a) begin
        extra_a <= next_wr_data[7:0];
      end
      if (wr_hit_b) begin
        extra_b <= next_wr_data[7:0];
      end
      if (wr_hit_ctrl) begin
        ctrl <= next_wr_data[7:0];
      end
    end
  end

  // Lanes only see new extra lane settings at link start, never mid-link
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_a    <= '0;
      live_b    <= '0;
      link_en_q <= 1'b0;
    end else begin
      link_en_q <= link_en;
      if (link_rise) begin
        live_a <= jxle_pkg::jxle_extra_t'(extra_a);
        live_b <= jxle_pkg::jxle_extra_t'(extra_b);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lanes_a             <= '0;
      lanes_b             <= '0;
      serial_subsystem_on <= 1'b1;
    end else begin
      lanes_a             <= next_lanes_a;
      lanes_b             <= next_lanes_b;
      serial_subsystem_on <= sub_on;
    end
  end

  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state      <= jxle_pkg::JXLE_WR_ACCEPT;
      aw_have       <= 1'b0;
      w_have        <= 1'b0;
      wr_addr       <= 12'h000;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= jxle_pkg::RESP_OKAY;
    end else begin
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      unique case (wr_state)
        jxle_pkg::JXLE_WR_ACCEPT: begin
          if (wr_commit) begin
            wr_state      <= jxle_pkg::JXLE_WR_RESP;
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= wr_ok ? jxle_pkg::RESP_OKAY : jxle_pkg::RESP_SLVERR;
          end else begin
            if (aw_fire) begin
              aw_have       <= 1'b1;
              s_axi_awready <= 1'b0;
            end
            if (w_fire) begin
              w_have       <= 1'b1;
              s_axi_wready <= 1'b0;
            end
          end
        end
        jxle_pkg::JXLE_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state      <= jxle_pkg::JXLE_WR_ACCEPT;
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
          end
        end
      endcase
    end
  end

  // Read channel; data is captured when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state      <= jxle_pkg::JXLE_RD_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= jxle_pkg::RESP_OKAY;
    end else begin
      unique case (rd_state)
        jxle_pkg::JXLE_RD_IDLE: begin
          if (ar_fire) begin
            rd_state      <= jxle_pkg::JXLE_RD_DATA;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? jxle_pkg::RESP_OKAY : jxle_pkg::RESP_SLVERR;
          end
        end
        jxle_pkg::JXLE_RD_DATA: begin
          if (s_axi_rready) begin
            rd_state      <= jxle_pkg::JXLE_RD_IDLE;
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule // jxle_top
`default_nettype wire

// ==== pkg/jxle_pkg.sv ====
// Constants and types for the extra serial lane enable control block
`default_nettype none
package jxle_pkg;
  localparam int          DATA_W       = 32;
  localparam int          ADDR_W       = 12;
  localparam int          LANES        = 8;
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_LINK_A   = 10'h20a;
  localparam logic [9:0]  IDX_LINK_B   = 10'h20b;
  localparam logic [9:0]  IDX_CTRL     = 10'h2f0;
  localparam logic [9:0]  IDX_STAT     = 10'h2f1;
  localparam logic [11:0] ADDR_LINK_A  = {IDX_LINK_A, 2'h0};
  localparam logic [11:0] ADDR_LINK_B  = {IDX_LINK_B, 2'h0};
  localparam logic [11:0] ADDR_CTRL    = {IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_STAT    = {IDX_STAT, 2'h0};
  // Extra lane register fields
  localparam int          SER_ON_BIT   = 0;
  localparam int          LANE_LSB     = 1;
  localparam int          LANE_MSB     = 7;
  localparam logic [7:0]  EXTRA_RST    = 8'h00;
  // Control register fields
  localparam int          LINK_EN_BIT  = 0;
  localparam int          PD_A_BIT     = 1;
  localparam int          PD_B_BIT     = 2;
  localparam int          TEST_LSB     = 4;
  localparam int          TEST_MSB     = 7;
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  // Test pattern codes
  localparam logic [3:0]  TEST_NONE    = 4'h0;
  localparam logic [3:0]  TEST_RAMP    = 4'h4;
  localparam logic [3:0]  TEST_ALT     = 4'h5;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [6:0] lanes;
    logic       ser_on;
  } jxle_extra_t;

  typedef struct packed {
    logic [7:0]      clk_en;
    logic [7:0]      ser_en;
    logic [7:0][3:0] pattern;
  } jxle_lanes_t;

  typedef enum logic [0:0] {
    JXLE_WR_ACCEPT = 1'b0,
    JXLE_WR_RESP   = 1'b1
  } jxle_wr_state_t;

  typedef enum logic [0:0] {
    JXLE_RD_IDLE = 1'b0,
    JXLE_RD_DATA = 1'b1
  } jxle_rd_state_t;
endpackage
`default_nettype wire

// ==== testbench/jxle_props.sv ====
// Port assertions for the extra lane enable block
`timescale 1ns/1ps
`default_nettype none
module jxle_props (
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire jxle_pkg::jxle_lanes_t lanes_a,
  input wire jxle_pkg::jxle_lanes_t lanes_b,
  input wire logic                  serial_subsystem_on
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // True when every serializer that runs has all lower lanes clocked
  function automatic logic low_ok(logic [7:0] s, logic [7:0] c);
    logic [7:0] m;
    low_ok = 1'b1;
    for (int n = 1; n < 8; n++) begin
      m = (8'h01 << n) - 8'h01;
      if (s[n] && (c & m) != m) low_ok = 1'b0;
    end
  endfunction
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_write_reopen: assert property ($fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
    else $error("write channels not reopened");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_read_reopen: assert property ($fell(s_axi_rvalid) |-> s_axi_arready)
    else $error("read channel not reopened");
  a_ser_has_clock: assert property (
    (lanes_a.ser_en & ~lanes_a.clk_en) == 8'h00 && (lanes_b.ser_en & ~lanes_b.clk_en) == 8'h00)
    else $error("serializer on without link clock");
  a_lower_lanes: assert property (
    low_ok(lanes_a.ser_en, lanes_a.clk_en) && low_ok(lanes_b.ser_en, lanes_b.clk_en))
    else $error("serializer clocked above a gap");
  a_reset_clear: assert property ($rose(aresetn) |-> lanes_a == '0 && lanes_b == '0)
    else $error("lanes active after reset");
  a_subsys_off: assert property (
    (!serial_subsystem_on)[*3] |-> lanes_a.clk_en == 8'h00 && lanes_b.clk_en == 8'h00)
    else $error("lanes clocked with subsystem off");
endmodule // jxle_props
`default_nettype wire

// ==== testbench/jxle_rx_model.sv ====
// Behavioural lane receiver that records which lanes deliver data
`timescale 1ns/1ps
`default_nettype none
module jxle_rx_model (
  input  wire logic                  aclk,
  input  wire jxle_pkg::jxle_lanes_t lanes_a,
  input  wire jxle_pkg::jxle_lanes_t lanes_b,
  output var  logic [7:0]            live_a,
  output var  logic [7:0]            live_b
);
  // A lane only delivers octets when serializer and link clock both run
  always_ff @(posedge aclk) begin
    live_a <= lanes_a.ser_en & lanes_a.clk_en;
    live_b <= lanes_b.ser_en & lanes_b.clk_en;
  end
endmodule // jxle_rx_model
`default_nettype wire

// ==== testbench/jxle_top_bench.sv ====
// Self-checking bench for the extra lane enable block
`timescale 1ns/1ps
`default_nettype none
module jxle_top_bench;
  logic                  aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic                  serial_subsystem_on;
  logic [1:0]            s_axi_bresp, s_axi_rresp, resp;
  logic [11:0]           s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]            s_axi_wstrb;
  logic [7:0]            format_lanes_a, format_lanes_b, live_a, live_b;
  jxle_pkg::jxle_lanes_t lanes_a, lanes_b;
  int                    fails, check_count;

  jxle_top jxle_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .format_lanes_a, .format_lanes_b, .lanes_a, .lanes_b, .serial_subsystem_on);
  jxle_rx_model jxle_rx_model_inst (.aclk, .lanes_a, .lanes_b, .live_a, .live_b);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Ready lines stay high so no task ever re-drives them in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask

  task automatic rd(input logic [11:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    resp    = s_axi_rresp;
  endtask

  // Extra settings go in with the link disabled, then ctl is written, which raises the link only if its LINK_EN_BIT is set
  task automatic apply(input logic [7:0] xa, input logic [7:0] xb, input logic [7:0] ctl);
    wr(jxle_pkg::ADDR_CTRL, 8'h00, 4'hf);
    wr(jxle_pkg::ADDR_LINK_A, xa, 4'hf);
    wr(jxle_pkg::ADDR_LINK_B, xb, 4'hf);
    wr(jxle_pkg::ADDR_CTRL, ctl, 4'hf);
    repeat (5) @(posedge aclk);
  endtask

  task automatic s_reset;
    chk({lanes_a.clk_en, lanes_b.clk_en, lanes_a.ser_en, lanes_b.ser_en}, 32'h00000000);
    rd(jxle_pkg::ADDR_LINK_A);
    chk(rd_data, 32'h00000000);
    rd(jxle_pkg::ADDR_LINK_B);
    chk(rd_data, 32'h00000000);
  endtask

  task automatic s_bus;
    wr(jxle_pkg::ADDR_LINK_A, 8'h55, 4'he);
    rd(jxle_pkg::ADDR_LINK_A);
    chk({rd_data[29:0], resp}, {30'h0, jxle_pkg::RESP_OKAY});
    wr(jxle_pkg::ADDR_LINK_B, 8'h55, 4'hf);
    rd(jxle_pkg::ADDR_LINK_B);
    chk(rd_data, 32'h00000055);
    wr(12'hffc, 8'h0f, 4'hf);
    chk({30'h0, resp}, {30'h0, jxle_pkg::RESP_SLVERR});
    rd(12'hffc);
    chk({30'h0, resp}, {30'h0, jxle_pkg::RESP_SLVERR});
    wr(jxle_pkg::ADDR_STAT, 8'h0f, 4'hf);
    chk({30'h0, resp}, {30'h0, jxle_pkg::RESP_SLVERR});
  endtask

  task automatic s_link_a;
    format_lanes_a <= 8'h01;
    format_lanes_b <= 8'h01;
    apply(8'h0e, 8'h00, 8'h01);
    chk({lanes_a.clk_en, lanes_a.ser_en, live_a, lanes_b.clk_en}, 32'h0f010101);
    chk({24'h0, lanes_a.pattern[1], lanes_a.pattern[0]}, 32'h00000040);
    rd(jxle_pkg::ADDR_STAT);
    chk(rd_data, 32'h0101010f);
    apply(8'h0f, 8'h00, 8'h01);
    chk({lanes_a.clk_en, lanes_a.ser_en, live_a, 8'h00}, 32'h0f0f0f00);
    apply(8'h0b, 8'h00, 8'h01);
    chk({lanes_a.clk_en, lanes_a.ser_en, live_a, 8'h00}, 32'h0b030300);
  endtask

  task automatic s_link_b;
    apply(8'h00, 8'hff, 8'h51);
    chk({lanes_b.clk_en, lanes_b.ser_en, live_b, lanes_a.clk_en}, 32'hffffff01);
    chk({24'h0, lanes_b.pattern[7], lanes_b.pattern[0]}, 32'h00000045);
    apply(8'h00, 8'h02, 8'h31);
    chk({lanes_b.clk_en, lanes_b.ser_en, 12'h000, lanes_b.pattern[1]}, 32'h03010003);
  endtask

  task automatic s_powerdown;
    apply(8'h0e, 8'h0e, 8'h03);
    chk({lanes_a.clk_en, lanes_b.clk_en, 15'h0, serial_subsystem_on}, 32'h000f0001);
    apply(8'h0e, 8'h0e, 8'h05);
    chk({lanes_a.clk_en, lanes_b.clk_en, 15'h0, serial_subsystem_on}, 32'h0f000001);
    apply(8'h0e, 8'h0e, 8'h07);
    chk({lanes_a.clk_en, lanes_b.clk_en, 15'h0, serial_subsystem_on}, 32'h00000000);
  endtask

  // Writes during an enabled link are stored but must not reach the lanes
  task automatic s_hold;
    apply(8'h0f, 8'h00, 8'h01);
    wr(jxle_pkg::ADDR_LINK_A, 8'h00, 4'hf);
    rd(jxle_pkg::ADDR_LINK_A);
    chk(rd_data, 32'h00000000);
    repeat (5) @(posedge aclk);
    chk({lanes_a.ser_en, 24'h0}, 32'h0f000000);
    // Old live settings must not show for even one cycle at the next start
    apply(8'h00, 8'h00, 8'h00);
    wr(jxle_pkg::ADDR_CTRL, 8'h01, 4'hf);
    repeat (4) begin
      @(posedge aclk);
      chk({25'h0, lanes_a.ser_en[7:1]}, 32'h00000000);
    end
    chk({lanes_a.ser_en, 24'h0}, 32'h01000000);
  endtask

  // Reset in mid-run with lanes active clears registers and lanes alike
  task automatic s_rereset;
    apply(8'h0f, 8'h0f, 8'h01);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({lanes_a.clk_en, lanes_b.clk_en, lanes_a.ser_en, lanes_b.ser_en}, 32'h00000000);
    rd(jxle_pkg::ADDR_LINK_A);
    chk(rd_data, 32'h00000000);
    rd(jxle_pkg::ADDR_LINK_B);
    chk(rd_data, 32'h00000000);
    rd(jxle_pkg::ADDR_CTRL);
    chk({rd_data[29:0], resp}, {30'h0, jxle_pkg::RESP_OKAY});
  endtask

  initial begin
    #100us;
    fails++;
    final_report();
  end

  initial begin
    aresetn        = 1'b0;
    s_axi_awaddr   = 12'h000;
    s_axi_awvalid  = 1'b0;
    s_axi_wdata    = 32'h00000000;
    s_axi_wstrb    = 4'h0;
    s_axi_wvalid   = 1'b0;
    s_axi_bready   = 1'b1;
    s_axi_araddr   = 12'h000;
    s_axi_arvalid  = 1'b0;
    s_axi_rready   = 1'b1;
    format_lanes_a = 8'h00;
    format_lanes_b = 8'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_reset();
    s_bus();
    s_link_a();
    s_link_b();
    s_powerdown();
    s_hold();
    s_rereset();
    final_report();
  end
endmodule // jxle_top_bench

bind jxle_top jxle_props jxle_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .lanes_a, .lanes_b,
  .serial_subsystem_on);
`default_nettype wire
